// File: logic/pba_consts.vh
// Constants for the secondary-bus request arbiter
// What this block does
// - Enable bit 0 admits internal request; resets 1
// - Enable bits 1-3 admit external masters; reset 1
// - Bit 9 selects external arbiter; resets 0
// - Bit 10 enables 16-cycle idle grant timeout
// - Timeout expiry drops grant, marks master broken
// - Refresh off: broken master excluded after REQ release
// - Refresh on: broken cleared after others served
// - Bits 19:12 fairness start value, reset 08h
// - Reload on new grant, decrement after FRAME_L
// - Fairness 00h never withdraws while REQ held
// - Toggle bit 20 clear keeps GNT_L asserted
// - Toggle set: GNT_L off one clock, two after
// - Priority bits 22-25 pick high or low group
`ifndef PBA_CONSTS_VH
`define PBA_CONSTS_VH

`define PBA_OFF_RSVD 8'h44
`define PBA_OFF_CTRL 8'h48

`define PBA_CTRL_RESET 32'h0040801f
`define PBA_CTRL_WMASK 32'h07dffe1f

`define PBA_EN_LSB 0
`define PBA_EN_MSB 3
`define PBA_EXT_ARB_BIT 9
`define PBA_BTO_EN_BIT 10
`define PBA_REFRESH_BIT 11
`define PBA_FAIR_LSB 12
`define PBA_FAIR_MSB 19
`define PBA_TOGGLE_BIT 20
`define PBA_PRIO_LSB 22
`define PBA_PRIO_MSB 25

`define PBA_BTO_CYCLES 5'h10
`define PBA_TOGGLE_DELAY 2'h2

`endif

// File: logic/pba_counter.v
// Loadable down counter that stops at zero
`timescale 1ns/1ps
`default_nettype none
module pba_counter #(
  parameter W = 8
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_load,
  input wire [W-1:0] i_load_val,
  input wire i_dec,
  output wire o_zero,
  output reg [W-1:0] o_count
);

  assign o_zero = (o_count == {W{1'b0}});

  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_count <= {W{1'b0}};
    end
    else if (i_load)
    begin
      o_count <= i_load_val;
    end
    else if (i_dec && !o_zero)
    begin
      o_count <= o_count - 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: logic/pba_rr_pick.v
// Rotating picker: first request after the last winner
`timescale 1ns/1ps
`default_nettype none
module pba_rr_pick #(
  parameter N = 4,
  parameter W = 2
) (
  input wire [N-1:0] i_req,
  input wire [W-1:0] i_last,
  output reg [N-1:0] o_pick,
  output wire o_any
);

  // N must equal 2**W so the index wraps by itself
  reg [W-1:0] idx;
  reg found;
  integer k;

  assign o_any = |i_req;

  always @*
  begin
    o_pick = {N{1'b0}};
    found = 1'b0;
    idx = i_last;
    for (k = 1; k <= N; k = k + 1)
    begin
      idx = i_last + k[W-1:0];
      if (!found && i_req[idx])
      begin
        o_pick[idx] = 1'b1;
        found = 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: logic/pba_arbiter.v
// Secondary-bus arbiter with its config register at 48h
`timescale 1ns/1ps
`default_nettype none
`include "pba_consts.vh"
module pba_arbiter #(
  parameter NREQ = 4
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_cfg_wr,
  input wire i_cfg_rd,
  input wire [7:0] i_cfg_addr,
  input wire [3:0] i_cfg_be,
  input wire [31:0] i_cfg_wdata,
  output reg [31:0] o_cfg_rdata,
  input wire i_int_req,
  input wire [NREQ-1:1] i_req_n,
  input wire i_frame_n,
  input wire i_irdy_n,
  output reg [NREQ-1:0] o_gnt_n,
  output reg [NREQ-1:0] o_broken
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_BUSY = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] ctrl;
  reg [NREQ-1:0] owner;
  reg [NREQ-1:0] next_owner;
  reg [1:0] last_idx;
  reg [NREQ-1:0] perm;
  reg [NREQ-1:0] served;
  reg [1:0] tog_cnt;
  reg frame_prev;
  reg grant_now;
  reg drop;
  reg mark_broken;
  reg toggle_off;
  reg [NREQ-1:0] refresh_clr;
  reg [NREQ-1:0] turn_mask;
  reg [1:0] win_idx;
  integer i;
  integer j;

  wire [NREQ-1:0] req;
  wire [NREQ-1:0] en;
  wire [NREQ-1:0] prio;
  wire ext_arb;
  wire bto_en;
  wire refresh_en;
  wire toggle_en;
  wire [7:0] fair_init;
  wire [NREQ-1:0] keep;
  wire [NREQ-1:0] eligible;
  wire [NREQ-1:0] hi_pick;
  wire [NREQ-1:0] lo_pick;
  wire hi_any;
  wire lo_any;
  wire [NREQ-1:0] winner;
  wire any_win;
  wire bus_idle;
  wire frame_fall;
  wire others_req;
  wire bto_zero;
  wire fair_zero;
  wire [4:0] bto_count;
  wire [7:0] fair_count;
  wire [31:0] be_mask;
  wire cfg_hit;

  assign req = {~i_req_n, i_int_req};
  assign en = ctrl[`PBA_EN_MSB:`PBA_EN_LSB];
  assign prio = ctrl[`PBA_PRIO_MSB:`PBA_PRIO_LSB];
  assign ext_arb = ctrl[`PBA_EXT_ARB_BIT];
  assign bto_en = ctrl[`PBA_BTO_EN_BIT];
  assign refresh_en = ctrl[`PBA_REFRESH_BIT];
  assign toggle_en = ctrl[`PBA_TOGGLE_BIT];
  assign fair_init = ctrl[`PBA_FAIR_MSB:`PBA_FAIR_LSB];

  // External arbiter mode empties every candidate set
  assign keep = req & en & {NREQ{~ext_arb}};
  assign eligible = keep & ~o_broken & ~perm;

  assign bus_idle = i_frame_n & i_irdy_n;
  assign frame_fall = frame_prev & ~i_frame_n;
  assign others_req = |(eligible & ~owner);

  // High group always beats low group
  pba_rr_pick #(
    .N(NREQ),
    .W(2)
  ) u_pick_hi (
    .i_req(eligible & prio),
    .i_last(last_idx),
    .o_pick(hi_pick),
    .o_any(hi_any)
  );

  pba_rr_pick #(
    .N(NREQ),
    .W(2)
  ) u_pick_lo (
    .i_req(eligible & ~prio),
    .i_last(last_idx),
    .o_pick(lo_pick),
    .o_any(lo_any)
  );

  assign winner = hi_any ? hi_pick : lo_pick;
  assign any_win = hi_any | lo_any;

  // Broken-master window, counted only on idle bus cycles
  pba_counter #(
    .W(5)
  ) u_bto (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_load(grant_now),
    .i_load_val(`PBA_BTO_CYCLES),
    .i_dec((state == ST_WAIT) && bus_idle && bto_en),
    .o_zero(bto_zero),
    .o_count(bto_count)
  );

  // Fairness budget, armed only once the owner's frame starts
  pba_counter #(
    .W(8)
  ) u_fair (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_load(grant_now),
    .i_load_val(fair_init),
    .i_dec((state == ST_BUSY) && others_req),
    .o_zero(fair_zero),
    .o_count(fair_count)
  );

  always @*
  begin
    win_idx = 2'h0;
    for (i = 0; i < NREQ; i = i + 1)
    begin
      if (winner[i])
      begin
        win_idx = i[1:0];
      end
    end
  end

  // A broken master returns once every other live master got a turn
  always @*
  begin
    refresh_clr = {NREQ{1'b0}};
    turn_mask = {NREQ{1'b0}};
    for (j = 0; j < NREQ; j = j + 1)
    begin
      turn_mask = served | ~en | o_broken | perm;
      turn_mask[j] = 1'b1;
      refresh_clr[j] = refresh_en & o_broken[j] & (&turn_mask);
    end
  end

  always @*
  begin
    next_state = state;
    next_owner = owner;
    grant_now = 1'b0;
    drop = 1'b0;
    mark_broken = 1'b0;
    toggle_off = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (any_win)
        begin
          grant_now = 1'b1;
          next_owner = winner;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (!(|(owner & keep)))
        begin
          drop = 1'b1;
        end
        else if (frame_fall)
        begin
          next_state = ST_BUSY;
        end
        else if (bto_en && bto_zero)
        begin
          mark_broken = 1'b1;
          drop = 1'b1;
        end
      end
      ST_BUSY:
      begin
        if (!(|(owner & keep)))
        begin
          drop = 1'b1;
        end
        else if ((fair_init != 8'h00) && fair_zero && others_req)
        begin
          drop = 1'b1;
        end
        else if (toggle_en && (tog_cnt == 2'h0))
        begin
          toggle_off = 1'b1;
        end
      end
      default:
      begin
        drop = 1'b1;
      end
    endcase
    if (drop)
    begin
      next_state = ST_IDLE;
      next_owner = {NREQ{1'b0}};
    end
  end

  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= ST_IDLE;
      owner <= {NREQ{1'b0}};
      o_gnt_n <= {NREQ{1'b1}};
      last_idx <= 2'h0;
      frame_prev <= 1'b1;
      tog_cnt <= 2'h0;
    end
    else
    begin
      state <= next_state;
      owner <= next_owner;
      frame_prev <= i_frame_n;
      // Grant follows the owner until it is dropped, and goes high for one clock when toggling
      o_gnt_n <= toggle_off ? {NREQ{1'b1}} : ~next_owner;
      if (grant_now)
      begin
        last_idx <= win_idx;
      end
      if (next_state != ST_BUSY)
      begin
        tog_cnt <= 2'h0;
      end
      else if ((state == ST_BUSY) && (tog_cnt != `PBA_TOGGLE_DELAY))
      begin
        tog_cnt <= tog_cnt + 2'h1;
      end
    end
  end

  // Marking is applied after the refresh clear so it is never lost
  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_broken <= {NREQ{1'b0}};
      perm <= {NREQ{1'b0}};
      served <= {NREQ{1'b0}};
    end
    else
    begin
      if (mark_broken)
      begin
        o_broken <= (o_broken & ~refresh_clr) | owner;
        served <= {NREQ{1'b0}};
      end
      else
      begin
        o_broken <= o_broken & ~refresh_clr;
        if (grant_now)
        begin
          served <= served | winner;
        end
      end
      // Once released with refresh off, the exclusion sticks
      perm <= perm | (o_broken & ~req & {NREQ{~refresh_en}});
    end
  end

  assign cfg_hit = ({i_cfg_addr[7:2], 2'b00} == `PBA_OFF_CTRL);
  assign be_mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                    {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};

  always @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl <= `PBA_CTRL_RESET;
      o_cfg_rdata <= 32'h00000000;
    end
    else
    begin
      if (i_cfg_wr && cfg_hit)
      begin
        ctrl <= (ctrl & ~(`PBA_CTRL_WMASK & be_mask)) |
                (i_cfg_wdata & `PBA_CTRL_WMASK & be_mask);
      end
      if (i_cfg_rd)
      begin
        // Reserved word at 44h and all other offsets read zero
        o_cfg_rdata <= cfg_hit ? ctrl : 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/pba_arbiter_sva.sv
// Port assertions for the secondary-bus arbiter
`timescale 1ns/1ps
`default_nettype none
module pba_arbiter_sva #(
  parameter NREQ = 4
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_cfg_rd,
  input wire i_int_req,
  input wire [NREQ-1:1] i_req_n,
  input wire i_frame_n,
  input wire [31:0] o_cfg_rdata,
  input wire [NREQ-1:0] o_gnt_n,
  input wire [NREQ-1:0] o_broken
);
  logic [4:0] idle;
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // Granted cycles on an idle bus, saturating
  always @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
      idle <= 5'h0;
    else if (&o_gnt_n || !i_frame_n)
      idle <= 5'h0;
    else if (idle != 5'h1f)
      idle <= idle + 5'h1;
  one_grant_a: assert property ($onehot0(~o_gnt_n))
    else $error("two grants");
  owner_gap_a: assert property (!(&o_gnt_n) && !(&$past(o_gnt_n))
    |-> o_gnt_n == $past(o_gnt_n)) else $error("no idle gap");
  int_req_a: assert property (!o_gnt_n[0] |-> $past(i_int_req))
    else $error("grant without request");
  ext_req_a: assert property (
    (~o_gnt_n[NREQ-1:1] & $past(i_req_n)) == 0) else $error("grant no req");
  broken_drop_a: assert property ((o_broken & ~$past(o_broken)) != 0
    |-> ##[0:1] &o_gnt_n) else $error("broken kept grant");
  timeout_wait_a: assert property (
    (o_broken & ~$past(o_broken)) != 0 |-> idle >= 5'd15)
    else $error("early timeout");
  shut_out_a: assert property (
    (o_broken & $past(o_broken) & ~o_gnt_n) == 0) else $error("broken granted");
  rsvd_zero_a: assert property ($past(i_cfg_rd) |->
    o_cfg_rdata[31:27] == 0 && o_cfg_rdata[8:5] == 0 && !o_cfg_rdata[21])
    else $error("reserved bit set");
  cover property (!o_gnt_n[0]);
  cover property ($rose(o_broken[1]));
  cover property ($fell(i_frame_n) && !o_gnt_n[1]);
endmodule
bind pba_arbiter pba_arbiter_sva #(.NREQ(NREQ)) sva_u (.i_core_clk, .i_rst,
  .i_cfg_rd, .i_int_req, .i_req_n, .i_frame_n, .o_cfg_rdata, .o_gnt_n,
  .o_broken);
`default_nettype wire

// File: tb/pba_masters.sv
// Behavioural external masters on the secondary bus
`timescale 1ns/1ps
`default_nettype none
module pba_masters (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [3:1] i_gnt_n,
  input wire logic [3:1] i_want,
  input wire logic [3:1] i_brk,
  output logic [3:1] o_req_n,
  output logic o_frame_n
);
  logic [3:0] cnt;
  logic [1:0] own;
  always @(posedge i_core_clk or posedge i_rst)
    if (i_rst)
    begin
      o_req_n <= 3'h7;
      o_frame_n <= 1'b1;
      cnt <= 4'h0;
      own <= 2'h1;
    end
    else
    begin
      // One idle REQ clock after a frame lets the arbiter rotate
      o_req_n <= ~i_want |
        ({3{cnt == 4'h1}} & (3'h1 << (own - 2'h1)));
      if (cnt > 4'h1)
        cnt <= cnt - 4'h1;
      if (cnt == 4'h1)
      begin
        o_frame_n <= 1'b1;
        cnt <= 4'h0;
      end
      for (int i = 1; i < 4; i++)
        if (!i_gnt_n[i] && !o_req_n[i] && !i_brk[i] && o_frame_n && cnt == 0)
        begin
          o_frame_n <= 1'b0;
          cnt <= 4'hc;
          own <= i[1:0];
        end
    end
endmodule
`default_nettype wire

// File: tb/pci_bus_request_arbiter_test.sv
// Self-checking bench for the secondary-bus arbiter
`timescale 1ns/1ps
`default_nettype none
module pci_bus_request_arbiter_test;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_int_req = 1'b0, i_frame_n;
  logic [7:0] i_cfg_addr = 8'h48;
  logic [31:0] i_cfg_wdata = 32'h0, o_cfg_rdata;
  logic [3:1] want = 3'h0, brk = 3'h0, i_req_n;
  logic [3:0] o_gnt_n, o_broken;
  int err_count = 0, checked = 0, n;
  always #10 i_core_clk = ~i_core_clk;
  pba_arbiter dut_u (.i_core_clk, .i_rst, .i_cfg_wr, .i_cfg_rd,
    .i_cfg_addr, .i_cfg_be(4'hf), .i_cfg_wdata, .o_cfg_rdata, .i_int_req,
    .i_req_n, .i_frame_n, .i_irdy_n(i_frame_n), .o_gnt_n, .o_broken);
  pba_masters ext_u (.i_core_clk, .i_rst, .i_gnt_n(o_gnt_n[3:1]),
    .i_want(want), .i_brk(brk), .o_req_n(i_req_n), .o_frame_n(i_frame_n));
  task automatic chk(string s, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic tk(int k);
    repeat (k) @(negedge i_core_clk);
  endtask
  task automatic go();
    i_rst = 1'b1;
    want = 3'h0;
    brk = 3'h0;
    tk(3);
    i_rst = 1'b0;
  endtask
  // One strobe cycle; read data is sampled as the strobe drops
  task automatic cfg(logic w, logic [7:0] a, logic [31:0] d);
    tk(1);
    i_cfg_wr = w;
    i_cfg_rd = !w;
    i_cfg_addr = a;
    i_cfg_wdata = d;
    tk(1);
    i_cfg_wr = 1'b0;
    i_cfg_rd = 1'b0;
  endtask
  task automatic wf();
    for (n = 0; n < 40 && i_frame_n !== 1'b0; n++)
      tk(1);
  endtask
  task automatic t_regs();
    go();
    cfg(1'b0, 8'h48, 0);
    chk("reset", o_cfg_rdata, 32'h0040801f);
    i_int_req = 1'b1;
    tk(3);
    chk("int on", o_gnt_n, 4'he);
    cfg(1'b1, 8'h48, 32'h0040801e);
    tk(2);
    chk("int off", o_gnt_n, 4'hf);
    i_int_req = 1'b0;
    cfg(1'b1, 8'h44, 32'hffffffff);
    cfg(1'b0, 8'h44, 0);
    chk("rsvd", o_cfg_rdata, 32'h0);
    cfg(1'b1, 8'h48, 32'hffffffff);
    cfg(1'b0, 8'h48, 0);
    chk("ctrl", o_cfg_rdata, 32'h07dffe1f);
    want = 3'h7;
    tk(5);
    chk("ext arb", o_gnt_n, 4'hf);
    $display("test regs done");
  endtask
  task automatic t_rot();
    logic [3:0] seen;
    seen = 4'h0;
    go();
    cfg(1'b1, 8'h48, 32'h00408017);
    want = 3'h7;
    repeat (80)
    begin
      tk(1);
      seen = seen | ~o_gnt_n;
    end
    chk("rotation", seen, 4'h6);
    $display("test rotation done");
  endtask
  task automatic t_tog(logic t);
    go();
    cfg(1'b1, 8'h48, t ? 32'h0050801f : 32'h0040801f);
    want = 3'h1;
    wf();
    tk(1);
    chk("gnt +1", o_gnt_n[1], 1'b0);
    tk(1);
    chk("gnt +2", o_gnt_n[1], t);
    tk(1);
    chk("gnt +3", o_gnt_n[1], 1'b0);
    $display("test toggle done");
  endtask
  // High-priority master 2 beats rotation; it never frames, timeout off
  task automatic t_prio();
    go();
    cfg(1'b1, 8'h48, 32'h0100801f);
    brk = 3'h2;
    want = 3'h3;
    tk(4);
    chk("prio", o_gnt_n, 4'hb);
    tk(30);
    chk("no timeout", o_gnt_n, 4'hb);
    chk("not broken", o_broken, 4'h0);
    $display("test priority done");
  endtask
  task automatic t_fair(logic [7:0] f);
    int b;
    go();
    cfg(1'b1, 8'h48, 32'h0040001f | {12'h0, f, 12'h0});
    want = 3'h3;
    wf();
    b = o_gnt_n[1] ? 2 : 1;
    for (n = 0; n < 20 && o_gnt_n[b] === 1'b0; n++)
      tk(1);
    chk("hold", f ? n >= 8 && n <= 10 : n >= 11, 1'b1);
    $display("test fairness done");
  endtask
  task automatic t_brk(logic r);
    go();
    cfg(1'b1, 8'h48, r ? 32'h00408c16 : 32'h00408416);
    brk = 3'h1;
    want = 3'h1;
    for (n = 0; n < 40 && o_gnt_n[1] !== 1'b0; n++)
      tk(1);
    for (n = 0; n < 40 && o_broken[1] !== 1'b1; n++)
      tk(1);
    chk("timeout", n >= 15 && n <= 18, 1'b1);
    tk(2);
    chk("dropped", o_gnt_n, 4'hf);
    want = 3'h0;
    tk(2);
    want = 3'h3;
    for (n = 0; n < 80 && o_broken[1] !== 1'b0; n++)
      tk(1);
    chk("refresh", o_broken[1], !r);
    $display("test broken done");
  endtask
  task automatic summarize();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    t_regs();
    t_rot();
    t_tog(1'b0);
    t_tog(1'b1);
    t_prio();
    t_fair(8'h08);
    t_fair(8'h00);
    t_brk(1'b0);
    t_brk(1'b1);
    summarize();
  end
  initial
  begin
    #40000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
